// >>> core/hdb_pkg.sv
`default_nettype none
package hdb_pkg;
  typedef enum logic [1:0] {SYM_ZERO = 2'h0, SYM_ONE = 2'h1, SYM_B = 2'h2, SYM_V = 2'h3} hdb_sym_t;
  typedef enum logic [1:0] {MODE_FULL = 2'h0, MODE_HALF = 2'h1, MODE_REMOTE = 2'h2, MODE_LOCAL = 2'h3} hdb_mode_t;
  typedef enum logic [2:0] {ST_RX = 3'h1, ST_TX = 3'h2, ST_FLUSH = 3'h4} hdb_dir_t;
  typedef struct packed {
    logic pos;
    logic neg;
  } hdb_pulse_t;
  typedef struct packed {
    logic bit_val;
    logic vld;
  } hdb_dent_t;
endpackage : hdb_pkg
`default_nettype wire

// >>> core/hdb_regs.svh
`ifndef HDB_REGS_SVH
`define HDB_REGS_SVH
`define HDB_FIFO_WIDTH 1
`define HDB_FIFO_DEPTH 8
`define HDB_RUN_LEN 4
`define HDB_ZRUN_LAST 2'h3
`define HDB_FLUSH_LAST 3'h3
`endif

// >>> core/hdb_transcoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "hdb_regs.svh"

module hdb_fifo #(
  parameter int WIDTH = `HDB_FIFO_WIDTH,
  parameter int DEPTH = `HDB_FIFO_DEPTH
) (
  input  wire logic             clock,     // bit clock
  input  wire logic             rst_n,     // sync reset
  input  wire logic             in_valid,  // write request
  input  wire logic [WIDTH-1:0] in_data,   // write data
  output logic                  in_ready,  // room left
  output logic                  out_valid, // data present
  output logic      [WIDTH-1:0] out_data,  // head entry
  input  wire logic             out_ready  // reader takes head
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // ready is registered so the top sees it straight from a flop
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count    <= '0;
      in_ready <= 1'b0;
    end else begin
      count    <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
    end
  end

  // pointers wrap naturally, so depth must be a power of two
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : hdb_fifo

// How it works
// - a tracker holds odd/even count of pulses (B included) since last violation, fed to encoder
// - the tracker updates on the falling edge, encoder pipeline on the rising edge
// - full duplex uses separate line input and output pins concurrently
// - half duplex shares one three-state pin pair, transmit or receive, never both
// - remote loop-back sends line input straight to line output, core detached
// - local loop-back feeds encoder output to decoder, line pins disconnected
// - encoder turns NRZ into separate positive and negative pulse outputs
// - decoder rebuilds NRZ data from the positive and negative pulse pair
// - decoder outputs four zeros for substitution patterns via a four-bit buffer
// - encoder detects four-zero runs, data delayed through a four-stage shift register
// - same-polarity successive pulses raise a flag unless part of a substitution
// - both pulses in one bit period raise the error flag
module hdb_transcoder import hdb_pkg::*; (
  input  wire logic      clock,                   // bit clock
  input  wire logic      rst_n,                   // sync reset
  input  wire hdb_mode_t mode,                    // duplex / loop-back select
  input  wire logic      nrz_serial_in,           // transmit bit
  input  wire logic      nrz_valid,               // transmit bit offered
  output logic           nrz_ready,               // fifo has room
  input  wire logic      line_pos_in,             // receive positive pulse
  input  wire logic      line_neg_in,             // receive negative pulse
  output logic           positive_pulse_out,      // transmit positive pulse
  output logic           negative_pulse_out,      // transmit negative pulse
  input  wire logic      io_pos_in,               // shared pin, positive, in
  input  wire logic      io_neg_in,               // shared pin, negative, in
  output logic           io_pos_out,              // shared pin, positive, out
  output logic           io_neg_out,              // shared pin, negative, out
  output logic           io_oe,                   // shared pins driven
  output logic           decoded_serial_out,      // received bit
  output logic           decoded_valid,           // received bit valid
  output logic           polarity_violation_flag, // stray violation
  output logic           pulse_error_flag         // both pulses at once
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  hdb_sym_t   pipe [`HDB_RUN_LEN];
  hdb_dent_t  dbuf [`HDB_RUN_LEN];
  hdb_dir_t   dir;
  hdb_pulse_t enc_pulse;
  hdb_pulse_t rx;
  logic [1:0] zrun;
  logic [2:0] flush_cnt;
  logic       fifo_valid;
  logic [0:0] fifo_data;
  logic       tx_ok;
  logic       flushing;
  logic       enc_step;
  logic       in_bit;
  logic       subst;
  logic       par_now;
  logic       mark_pos;
  logic       emit;
  logic       enc_is_v;
  logic       last_pol;
  logic       odd_even;
  logic       oe_d;
  logic       rx_active;
  logic       dec_pulse;
  logic       dec_viol;
  logic       dec_sub;
  logic       seen_pulse;
  logic       last_rx_pos;

  hdb_fifo #(.WIDTH(`HDB_FIFO_WIDTH), .DEPTH(`HDB_FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (nrz_valid),
    .in_data   (nrz_serial_in),
    .in_ready  (nrz_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (tx_ok)
  );

  // encoder pulls data in every mode, but in half duplex only while it owns the line
  assign tx_ok    = (mode == MODE_HALF) ? (dir == ST_TX) : 1'b1;
  assign flushing = dir == ST_FLUSH;
  assign enc_step = (fifo_valid && tx_ok) || flushing;
  assign in_bit   = !flushing && fifo_data[0];
  // flush zeros only push data out; substituting them would leave a stray V in the pipe
  assign subst    = enc_step && !flushing && !in_bit && zrun == `HDB_ZRUN_LAST;
  // parity seen by the decision includes the symbol leaving at this edge
  assign par_now  = (pipe[`HDB_RUN_LEN-1] == SYM_V) ? 1'b0
                  : odd_even ^ (pipe[`HDB_RUN_LEN-1] != SYM_ZERO);
  assign emit     = pipe[`HDB_RUN_LEN-1] != SYM_ZERO;
  assign mark_pos = (pipe[`HDB_RUN_LEN-1] == SYM_V) ? last_pol : !last_pol;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      zrun <= '0;
    end else if (enc_step) begin
      zrun <= (subst || in_bit || flushing) ? 2'h0 : zrun + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pipe[0] <= SYM_ZERO;
    end else if (enc_step) begin
      pipe[0] <= subst ? SYM_V : (in_bit ? SYM_ONE : SYM_ZERO);
    end
  end

  for (genvar i = 1; i < `HDB_RUN_LEN; i++) begin : g_pipe
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        pipe[i] <= SYM_ZERO;
      end else if (enc_step) begin
        // even count: oldest zero of the run becomes the balancing pulse
        pipe[i] <= (i == `HDB_RUN_LEN-1 && subst && !par_now) ? SYM_B : pipe[i-1];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enc_pulse <= '0;
      enc_is_v  <= 1'b0;
      last_pol  <= 1'b0;
    end else if (enc_step) begin
      enc_pulse <= '{pos: emit && mark_pos, neg: emit && !mark_pos};
      enc_is_v  <= pipe[`HDB_RUN_LEN-1] == SYM_V;
      last_pol  <= emit ? mark_pos : last_pol;
    end else begin
      enc_pulse <= '0;
      enc_is_v  <= 1'b0;
    end
  end

  // falling edge: the next rising-edge decision never sees a stale count
  always_ff @(negedge clock) begin
    if (!rst_n) begin
      odd_even <= 1'b0;
    end else if (enc_is_v) begin
      odd_even <= 1'b0;
    end else if (enc_pulse.pos || enc_pulse.neg) begin
      odd_even <= !odd_even;
    end
  end

  parity_clear_a: assert property (enc_is_v |-> !odd_even)
    else $error("parity not cleared after violation");
  parity_toggle_a: assert property ((enc_pulse.pos || enc_pulse.neg) && !enc_is_v
    |-> odd_even != $past(odd_even))
    else $error("parity did not toggle on a pulse");
  pulse_excl_a: assert property (!(enc_pulse.pos && enc_pulse.neg))
    else $error("encoder drove both pulses");
  subst_v_a: assert property (subst |=> pipe[0] == SYM_V)
    else $error("four-zero run not replaced");
  v_polarity_a: assert property (enc_step && pipe[`HDB_RUN_LEN-1] == SYM_V
    |=> enc_pulse.pos == $past(last_pol) && (enc_pulse.pos || enc_pulse.neg))
    else $error("violation pulse has wrong polarity");
  cov_subst_c: cover property (subst ##[1:8] subst);

  // half duplex: own the pins while data waits, then flush the pipe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dir       <= ST_RX;
      flush_cnt <= 3'h0;
    end else begin
      case (dir)
        ST_RX: begin
          if (mode == MODE_HALF && fifo_valid) begin
            dir <= ST_TX;
          end
        end
        ST_TX: begin
          if (!fifo_valid || mode != MODE_HALF) begin
            dir       <= ST_FLUSH;
            flush_cnt <= 3'h0;
          end
        end
        ST_FLUSH: begin
          flush_cnt <= flush_cnt + 1'b1;
          if (flush_cnt == `HDB_FLUSH_LAST) begin
            dir <= ST_RX;
          end
        end
        default: dir <= ST_RX;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      positive_pulse_out <= 1'b0;
      negative_pulse_out <= 1'b0;
      io_pos_out         <= 1'b0;
      io_neg_out         <= 1'b0;
      io_oe              <= 1'b0;
      oe_d               <= 1'b0;
    end else begin
      oe_d               <= dir != ST_RX;
      // one extra cycle so the last flushed symbol still reaches the pin
      io_oe              <= (mode == MODE_HALF) && (dir != ST_RX || oe_d);
      io_pos_out         <= (mode == MODE_HALF) && enc_pulse.pos;
      io_neg_out         <= (mode == MODE_HALF) && enc_pulse.neg;
      case (mode)
        MODE_FULL: begin
          positive_pulse_out <= enc_pulse.pos;
          negative_pulse_out <= enc_pulse.neg;
        end
        MODE_REMOTE: begin
          positive_pulse_out <= line_pos_in;
          negative_pulse_out <= line_neg_in;
        end
        default: begin
          positive_pulse_out <= 1'b0;
          negative_pulse_out <= 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    rx = '0;
    case (mode)
      MODE_FULL:  rx = '{pos: line_pos_in, neg: line_neg_in};
      MODE_HALF:  rx = io_oe ? hdb_pulse_t'('0) : hdb_pulse_t'({io_pos_in, io_neg_in});
      MODE_LOCAL: rx = enc_pulse;
      default:    rx = '0;
    endcase
  end

  assign rx_active = mode != MODE_REMOTE && !(mode == MODE_HALF && io_oe);
  assign dec_pulse = rx.pos ^ rx.neg;
  assign dec_viol  = dec_pulse && seen_pulse && rx.pos == last_rx_pos;
  // a violation counts as substitution only after two zeros (000V or B00V)
  assign dec_sub   = dec_viol && !dbuf[0].bit_val && !dbuf[1].bit_val;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seen_pulse  <= 1'b0;
      last_rx_pos <= 1'b0;
    end else if (dec_pulse) begin
      seen_pulse  <= 1'b1;
      last_rx_pos <= rx.pos;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dbuf[0] <= '0;
    end else begin
      dbuf[0] <= '{bit_val: dec_pulse && !dec_sub, vld: rx_active};
    end
  end

  for (genvar i = 1; i < `HDB_RUN_LEN; i++) begin : g_dbuf
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        dbuf[i] <= '0;
      end else begin
        dbuf[i] <= '{bit_val: dbuf[i-1].bit_val && !dec_sub, vld: dbuf[i-1].vld};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      decoded_serial_out      <= 1'b0;
      decoded_valid           <= 1'b0;
      polarity_violation_flag <= 1'b0;
      pulse_error_flag        <= 1'b0;
    end else begin
      decoded_serial_out      <= dbuf[`HDB_RUN_LEN-1].bit_val;
      decoded_valid           <= dbuf[`HDB_RUN_LEN-1].vld;
      polarity_violation_flag <= rx_active && dec_viol && !dec_sub;
      pulse_error_flag        <= rx_active && rx.pos && rx.neg;
    end
  end

  reset_quiet_a: assert property ($rose(rst_n) |-> !positive_pulse_out && !negative_pulse_out
    && !io_oe && !polarity_violation_flag && !pulse_error_flag)
    else $error("outputs not cleared by reset");
  zero_out_a: assert property (dec_sub |-> ##2 (!decoded_serial_out) [*4])
    else $error("substitution not decoded as four zeros");
  mark_in_a: assert property (dec_pulse && !dec_viol |=> dbuf[0].bit_val)
    else $error("single pulse not decoded as one");
  viol_flag_a: assert property (rx_active && dec_viol |=> polarity_violation_flag == !$past(dec_sub))
    else $error("violation flag wrong");
  err_flag_a: assert property (rx_active && rx.pos && rx.neg |=> pulse_error_flag)
    else $error("simultaneous pulses not flagged");
  half_excl_a: assert property (mode == MODE_HALF && io_oe |-> rx == hdb_pulse_t'('0))
    else $error("receiving while driving shared pins");
  remote_loop_a: assert property (mode == MODE_REMOTE |=> positive_pulse_out == $past(line_pos_in)
    && negative_pulse_out == $past(line_neg_in) && !decoded_valid [*1])
    else $error("remote loop-back path broken");
  local_loop_a: assert property (mode == MODE_LOCAL |-> rx == enc_pulse ##1
    (!positive_pulse_out && !negative_pulse_out))
    else $error("local loop-back not isolated");
  full_path_a: assert property (mode == MODE_FULL |-> rx == hdb_pulse_t'({line_pos_in, line_neg_in}))
    else $error("full duplex receive path wrong");
  cov_dsub_c: cover property (dec_sub);
  cov_flush_c: cover property (dir == ST_FLUSH ##[1:8] dir == ST_RX);
  cov_full_c: cover property (!nrz_ready);
endmodule : hdb_transcoder
`default_nettype wire

// >>> dv/hdb_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module hdb_line_model import hdb_pkg::*; (
  input  wire logic       clock,  // bit clock
  input  wire logic       inject, // 1: far end sends pat, 0: cable loop
  input  wire hdb_pulse_t pat,    // far-end symbol
  input  wire hdb_pulse_t tx,     // device line output
  input  wire logic       io_oe,  // device drives shared pins
  input  wire hdb_pulse_t io_tx,  // device shared-pin drive
  output var  hdb_pulse_t rx,     // device line input
  output var  hdb_pulse_t io_rx   // shared wire level
);
  hdb_pulse_t cable;

  always_ff @(posedge clock) begin
    cable <= tx;
  end

  assign rx = inject ? pat : cable;
  // terminated wire rests at zero; far end keeps quiet while the device talks
  assign io_rx = io_oe ? io_tx : (inject ? pat : 2'h0);
endmodule : hdb_line_model
`default_nettype wire

// >>> dv/hdb_transcoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hdb_transcoder_tb import hdb_pkg::*; ;
  localparam logic [47:0] PAT = 48'h840609a30000;
  localparam logic [31:0] ENC = 32'h08403000;
  logic       clock, rst_n, nrz_serial_in, nrz_valid, nrz_ready, inject;
  hdb_mode_t  mode;
  hdb_pulse_t pat, rx, io_rx, tx_p, io_tx_p;
  logic       pos_out, neg_out, io_pos_out, io_neg_out, io_oe;
  logic       dec_out, dec_vld, pv_flag, err_flag;
  logic [1:0] syms[$];
  logic       dbits[$];
  int         error_cnt = 0, n_compared = 0;
  int         pv_n, er_n, oe_n, iop_n, bad_n, ln_n;

  assign tx_p    = {pos_out, neg_out};
  assign io_tx_p = {io_pos_out, io_neg_out};

  hdb_transcoder i_hdb_transcoder (.clock(clock), .rst_n(rst_n), .mode(mode),
    .nrz_serial_in(nrz_serial_in), .nrz_valid(nrz_valid), .nrz_ready(nrz_ready),
    .line_pos_in(rx.pos), .line_neg_in(rx.neg), .positive_pulse_out(pos_out),
    .negative_pulse_out(neg_out), .io_pos_in(io_rx.pos), .io_neg_in(io_rx.neg),
    .io_pos_out(io_pos_out), .io_neg_out(io_neg_out), .io_oe(io_oe),
    .decoded_serial_out(dec_out), .decoded_valid(dec_vld),
    .polarity_violation_flag(pv_flag), .pulse_error_flag(err_flag));

  hdb_line_model i_hdb_line_model (.clock(clock), .inject(inject), .pat(pat), .tx(tx_p),
    .io_oe(io_oe), .io_tx(io_tx_p), .rx(rx), .io_rx(io_rx));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // outputs read at the edge hold the settled pre-edge values
  always @(posedge clock) begin
    if (syms.size() > 0 || (pos_out | neg_out) === 1'b1) syms.push_back({pos_out, neg_out});
    if (dec_vld === 1'b1 && (dbits.size() > 0 || dec_out === 1'b1)) dbits.push_back(dec_out);
    pv_n += (pv_flag === 1'b1);
    er_n += (err_flag === 1'b1);
    oe_n += (io_oe === 1'b1);
    ln_n += ((pos_out | neg_out) === 1'b1);
    if ((io_pos_out | io_neg_out) === 1'b1) begin
      if (io_oe === 1'b1) iop_n++;
      else bad_n++;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic start(input hdb_mode_t m);
    @(posedge clock);
    mode      <= m;
    rst_n     <= 1'b0;
    nrz_valid <= 1'b0;
    inject    <= 1'b0;
    pat       <= 2'h0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    syms.delete();
    dbits.delete();
    {pv_n, er_n, oe_n, iop_n, bad_n, ln_n} = '0;
  endtask : start

  // holds the bit until the fifo takes it
  task automatic push_bits(input logic [31:0] v, input int n);
    int i;
    int k;
    for (i = 0; i < n; i++) begin
      nrz_valid     <= 1'b1;
      nrz_serial_in <= v[n-1-i];
      for (k = 0; k < 50; k++) begin
        @(posedge clock);
        if (nrz_ready === 1'b1) break;
      end
      if (k == 50) begin
        check(16'h0, 16'h1, "fifo never ready");
        results();
      end
    end
    nrz_valid <= 1'b0;
  endtask : push_bits

  task automatic cmp_bits(input logic [31:0] v, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      check(i < dbits.size() ? dbits[i] : 1'bx, v[n-1-i], "decoded bit");
    end
  endtask : cmp_bits

  task automatic enc_scn();
    logic [1:0] e[$];
    int cnt;
    int i;
    logic last;
    cnt  = 0;
    last = 1'b0; // so the first mark goes out positive
    i    = 0;
    while (i < 28) begin
      if (i < 25 && ENC[27-i -: 4] == 4'h0) begin
        if (cnt % 2 == 1) e.push_back(2'h0);
        else begin
          last = !last;
          e.push_back({last, !last});
        end
        e.push_back(2'h0);
        e.push_back(2'h0);
        e.push_back({last, !last});
        cnt = 0;
        i += 4;
      end else if (ENC[27-i]) begin
        last = !last;
        e.push_back({last, !last});
        cnt++;
        i++;
      end else begin
        e.push_back(2'h0);
        i++;
      end
    end
    start(MODE_FULL);
    push_bits(ENC, 28);
    repeat (20) @(posedge clock);
    for (i = 0; i < 20; i++) begin
      check(i < syms.size() ? syms[i] : 2'bxx, e[i], "line symbol");
    end
    cmp_bits(ENC >> 8, 20);
  endtask : enc_scn

  task automatic dec_scn();
    int i;
    start(MODE_FULL);
    inject <= 1'b1;
    for (i = 0; i < 24; i++) begin
      pat <= PAT[47-2*i -: 2];
      @(posedge clock);
    end
    repeat (10) @(posedge clock);
    cmp_bits(32'ha01c, 16);
    check(16'(pv_n), 16'h1, "violation flags");
    check(16'(er_n), 16'h1, "error flags");
  endtask : dec_scn

  task automatic remote_scn();
    int i;
    start(MODE_REMOTE);
    inject <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      pat <= PAT[47-2*i -: 2];
      #1;
      if (i > 0) check({dec_vld, pos_out, neg_out}, PAT[49-2*i -: 2], "remote echo");
    end
  endtask : remote_scn

  task automatic local_scn();
    start(MODE_LOCAL);
    inject <= 1'b1;
    pat    <= 2'h2;
    push_bits(ENC, 28);
    repeat (20) @(posedge clock);
    check(16'(ln_n + oe_n), 16'h0, "line pins active");
    cmp_bits(ENC >> 8, 20);
  endtask : local_scn

  task automatic half_scn();
    int k;
    start(MODE_HALF);
    inject <= 1'b1;
    pat    <= 2'h2;
    push_bits(32'hd, 4);
    for (k = 0; k < 100 && !(oe_n > 0 && io_oe === 1'b0); k++) @(posedge clock);
    check(16'(k < 100), 16'h1, "turnaround bound");
    check(16'(ln_n), 16'h0, "full-duplex pins used");
    check(16'(bad_n), 16'h0, "drive without enable");
    check(16'(iop_n >= 3), 16'h1, "shared pin marks");
  endtask : half_scn

  task automatic reset_scn();
    start(MODE_FULL);
    inject <= 1'b1;
    pat    <= 2'h3;
    push_bits(32'hff, 8);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check({nrz_ready, pos_out, neg_out, io_pos_out, io_neg_out, io_oe, dec_out, dec_vld, pv_flag, err_flag},
          16'h0, "outputs in reset");
  endtask : reset_scn

  initial begin
    rst_n         = 1'b0;
    mode          = MODE_FULL;
    nrz_serial_in = 1'b0;
    nrz_valid     = 1'b0;
    inject        = 1'b0;
    pat           = 2'h0;
    enc_scn();
    dec_scn();
    remote_scn();
    local_scn();
    half_scn();
    reset_scn();
    results();
  end
endmodule : hdb_transcoder_tb
`default_nettype wire
